//--- isahc_regs.svh
// constants for the isa host address and data cycle sequencer
// How it works
// - for eight-bit targets the host moves the upper data byte onto the low lanes.
// - a sixteen-bit cycle to an eight-bit target becomes two bus cycles automatically.
// - i/o decoding uses address bits 0 to 15 only.
// - memory cycles drive twenty latched address bits 0 to 19.
// - unlatched upper address lines 17 to 23 are driven too, reaching 16 MB.
// - latched address follows while the latch enable is high, holds after its fall.
// - one active-high latch enable pulse starts every host-initiated bus cycle.
// - the latch enable marks when address, upper lines and aen are valid; on a split the byte enable is deasserted as it falls.
// - the active-low upper-byte enable is asserted when upper lanes carry data.
// - aen is high through dma cycles and low during cpu cycles.
// - split only when the sixteen-bit chip select stays high; else one wide cycle.
`ifndef ISAHC_REGS_SVH
`define ISAHC_REGS_SVH
`define ISAHC_BALE_CYCLES 2
`define ISAHC_DATA_CYCLES 6
`define ISAHC_SA_W 20
`define ISAHC_IO_W 16
`endif

//--- isahc_pkg.sv
// types for the isa host address and data cycle sequencer
package isahc_pkg;
  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_ALE = 4'h2,
    ST_DATA = 4'h4,
    ST_GAP = 4'h8
  } isahc_state_t;
  typedef struct packed {
    logic [23:0] addr;
    logic [15:0] wdata;
    logic wide;
    logic is_io;
    logic is_dma;
    logic write;
  } isahc_req_t;
  typedef struct packed {
    isahc_state_t st;
    isahc_req_t req;
    logic second;
    logic narrow;
    logic [3:0] cnt;
    logic bale;
    logic sbhe_n;
    logic aen;
    logic [19:0] sa;
    logic [6:0] la;
    logic [15:0] sd_o;
    logic [1:0] sd_oe;
    logic [15:0] rdata;
    logic busy;
    logic done;
  } isahc_s_t;
endpackage

//--- isahc_cycle.sv
// host-side isa address phase, byte steering and sixteen-to-eight split
`timescale 1ns/1ns
`include "isahc_regs.svh"
module isahc_cycle
  import isahc_pkg::*;
#(
  parameter int BALE_CYCLES = `ISAHC_BALE_CYCLES,
  parameter int DATA_CYCLES = `ISAHC_DATA_CYCLES
)
(
  // clock and reset
  input wire logic mclk_in,
  input wire logic rst_in,
  // cpu or dma request
  input wire logic req_valid_in,
  input wire isahc_req_t req_in,
  output logic busy_out,
  output logic done_out,
  output logic [15:0] rdata_out,
  // bus pins
  input wire logic cs16_n_in,
  input wire logic [15:0] sd_in,
  output logic [15:0] sd_out,
  output logic [1:0] sd_oe_out,
  output logic [19:0] sa_out,
  output logic [6:0] la_out,
  output logic bale_out,
  output logic sbhe_n_out,
  output logic aen_out
);
  // one bus cycle runs idle -> latch pulse -> data window -> gap.
  // a wide request to an eight-bit target loops from the gap back to a
  // second latch pulse with address bit 0 set, so software sees one access.
  // chip select 16 is only trusted at the last latch cycle: the target
  // decodes it from the address, which is not settled before that.
  // trade-off: the byte enable may drop after the pulse when a split
  // is found, one cycle late for a target that latched it early.
  // strobes and wait states live elsewhere; the data window is fixed.
  isahc_s_t s_q;
  isahc_s_t s_d;

  ////////////////////////////////////////////////////////////////
  // counters run from n-1 down to zero, so each phase lasts n cycles
  function automatic logic [3:0] cnt_of(input int n);
    cnt_of = 4'(n - 1);
  endfunction

  // write byte that an eight-bit target sees on its low lanes
  function automatic logic [15:0] low_lane_of(input logic [15:0] w, input logic hi);
    low_lane_of = hi ? {8'h00, w[15:8]} : {8'h00, w[7:0]};
  endfunction

  ////////////////////////////////////////////////////////////////
  // next state and every pin decided in one place
  always_comb
  begin
    s_d = s_q;
    // done is a one-cycle pulse, cleared unless the gap sets it
    s_d.done = 1'b0;
    case (s_q.st)
      ST_IDLE:
      begin
        s_d.bale = 1'b0;
        s_d.sbhe_n = 1'b1;
        s_d.aen = 1'b0;
        s_d.sd_oe = 2'h0;
        // a request while busy never reaches this point, so it is dropped
        if (req_valid_in)
        begin
          s_d.req = req_in;
          s_d.second = 1'b0;
          s_d.narrow = 1'b0;
          s_d.busy = 1'b1;
          s_d.st = ST_ALE;
          s_d.cnt = cnt_of(BALE_CYCLES);
          s_d.bale = 1'b1;
          // dma marks the whole transfer, both halves of a split included
          s_d.aen = req_in.is_dma;
          // i/o cycles carry only the low sixteen bits
          s_d.sa = req_in.is_io ? {4'h0, req_in.addr[15:0]} : req_in.addr[19:0];
          // memory cycles keep all twenty bits and the seven upper lines
          s_d.la = req_in.is_io ? 7'h00 : req_in.addr[23:17];
          // a wide access or an odd byte asserts the upper-byte enable
          s_d.sbhe_n = ~(req_in.wide | req_in.addr[0]);
          // a wide access always starts on the even byte, so the latched
          // address never moves after the pulse falls
          s_d.sa[0] = req_in.addr[0] & ~req_in.wide;
        end
      end
      ST_ALE:
      begin
        // address presented with bale, then held after its fall
        if (s_q.cnt == 4'h0)
        begin
          s_d.bale = 1'b0;
          s_d.st = ST_DATA;
          s_d.cnt = cnt_of(DATA_CYCLES);
          // chip select sampled after the address is valid
          s_d.narrow = s_q.req.wide & cs16_n_in & ~s_q.second;
          if (s_q.req.wide & cs16_n_in & ~s_q.second)
          begin
            // low byte first; address bit 0 already low since the take
            s_d.sbhe_n = 1'b1;
          end
          if (s_q.req.write)
          begin
            if (s_q.second)
            begin
              s_d.sd_o = low_lane_of(s_q.req.wdata, 1'b1);
              s_d.sd_oe = 2'h1;
            end
            else if (s_q.req.wide & ~cs16_n_in)
            begin
              // both lanes only when the target claimed sixteen bits
              s_d.sd_o = s_q.req.wdata;
              s_d.sd_oe = 2'h3;
            end
            else
            begin
              // odd single byte to an eight-bit target still uses low lanes
              s_d.sd_o = low_lane_of(s_q.req.wdata, s_q.req.addr[0]);
              s_d.sd_oe = 2'h1;
            end
          end
        end
        else
          s_d.cnt = s_q.cnt - 4'h1;
      end
      // read data is taken at the last data cycle, after the target
      // has had the whole window to settle its lanes
      ST_DATA:
      begin
        if (s_q.cnt == 4'h0)
        begin
          // stop driving before the gap so two drivers never meet
          s_d.sd_oe = 2'h0;
          if (~s_q.req.write)
          begin
            // the high byte of a split read comes back on the low lanes
            if (s_q.second)
              s_d.rdata[15:8] = sd_in[7:0];
            else if (s_q.narrow | ~s_q.req.wide)
              s_d.rdata = s_q.sa[0] ? {sd_in[7:0], 8'h00} : {8'h00, sd_in[7:0]};
            else
              s_d.rdata = sd_in;
          end
          s_d.st = ST_GAP;
        end
        else
          s_d.cnt = s_q.cnt - 4'h1;
      end
      // one idle cycle lets the target release the lanes
      ST_GAP:
      begin
        if (s_q.narrow)
        begin
          // second half, no software involvement
          // aen and the upper lines stay; only address bit 0 moves
          s_d.narrow = 1'b0;
          s_d.second = 1'b1;
          s_d.st = ST_ALE;
          s_d.cnt = cnt_of(BALE_CYCLES);
          s_d.bale = 1'b1;
          s_d.sa[0] = 1'b1;
          s_d.sbhe_n = 1'b1;
        end
        else
        begin
          s_d.st = ST_IDLE;
          s_d.busy = 1'b0;
          s_d.done = 1'b1;
          s_d.bale = 1'b0;
          s_d.sbhe_n = 1'b1;
          s_d.aen = 1'b0;
        end
      end
      // an illegal one-hot code falls back to idle
      default:
        s_d.st = ST_IDLE;
    endcase
  end

  ////////////////////////////////////////////////////////////////
  // synchronous reset, one edge is enough
  always_ff @(posedge mclk_in)
  begin
    if (rst_in)
    begin
      // every field named, so no stale request survives a reset
      s_q.st <= ST_IDLE;
      s_q.req <= '0;
      s_q.second <= 1'b0;
      s_q.narrow <= 1'b0;
      s_q.cnt <= 4'h0;
      s_q.bale <= 1'b0;
      s_q.sbhe_n <= 1'b1;
      s_q.aen <= 1'b0;
      s_q.sa <= 20'h00000;
      s_q.la <= 7'h00;
      s_q.sd_o <= 16'h0000;
      s_q.sd_oe <= 2'h0;
      s_q.rdata <= 16'h0000;
      s_q.busy <= 1'b0;
      s_q.done <= 1'b0;
    end
    else
      s_q <= s_d;
  end

  ////////////////////////////////////////////////////////////////
  // every pin comes straight from the state register, so no decode
  // glitch reaches the bus while the latch enable is high
  assign busy_out = s_q.busy;
  assign done_out = s_q.done;
  assign rdata_out = s_q.rdata;
  assign sd_out = s_q.sd_o;
  assign sd_oe_out = s_q.sd_oe;
  assign sa_out = s_q.sa;
  assign la_out = s_q.la;
  assign bale_out = s_q.bale;
  assign sbhe_n_out = s_q.sbhe_n;
  assign aen_out = s_q.aen;
endmodule

//--- isahc_cycle_properties.sv
// bound assertions for the isa host cycle sequencer
`timescale 1ns/1ns
module isahc_cycle_props
  import isahc_pkg::*;
(
  // clock and reset
  input wire logic mclk_in,
  input wire logic rst_in,
  // request side
  input wire logic req_valid_in,
  input wire isahc_req_t req_in,
  input wire logic busy_out,
  input wire logic done_out,
  // bus pins
  input wire logic cs16_n_in,
  input wire logic [15:0] sd_out,
  input wire logic [1:0] sd_oe_out,
  input wire logic [19:0] sa_out,
  input wire logic [6:0] la_out,
  input wire logic bale_out,
  input wire logic sbhe_n_out,
  input wire logic aen_out
);
  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (rst_in);
  sequence s_take;
    req_valid_in && !busy_out;
  endsequence
  // chip select is looked at while the latch enable is still high
  sequence s_wide;
    s_take ##0 req_in.wide ##2 1'b1;
  endsequence
  bale_pulse_a: assert property (s_take |=> bale_out [*2] ##1 !bale_out)
    else $error("bad latch pulse");
  addr_hold_a: assert property (!bale_out ##1 !bale_out |-> $stable({sa_out, la_out, aen_out}))
    else $error("address moved while latched");
  aen_kind_a: assert property (s_take |=> aen_out == $past(req_in.is_dma))
    else $error("bad aen");
  property p_mem_addr;
    s_take ##0 !req_in.is_io |=> sa_out == $past(req_in.addr[19:0])
      && la_out == $past(req_in.addr[23:17]);
  endproperty
  mem_addr_a: assert property (p_mem_addr)
    else $error("bad memory address");
  io_addr_a: assert property (s_take ##0 req_in.is_io |=> sa_out[19:16] == 4'h0 && la_out == 7'h0)
    else $error("bad io address");
  byte_high_a: assert property (s_take ##0 !req_in.wide |=> sbhe_n_out == !$past(req_in.addr[0]))
    else $error("bad byte enable");
  // second half: new pulse, odd address, no upper byte enable
  sequence s_second;
    bale_out && sa_out[0] && sbhe_n_out;
  endsequence
  property p_split;
    s_wide ##0 cs16_n_in |-> !sa_out[0] ##8 s_second ##9 done_out;
  endproperty
  split_seq_a: assert property (p_split)
    else $error("bad split");
  wide_once_a: assert property (s_wide ##0 !cs16_n_in |-> !sbhe_n_out ##8 done_out)
    else $error("bad wide cycle");
  property p_steer;
    s_take ##0 req_in.write && !req_in.wide && req_in.addr[0] |->
      ##3 sd_oe_out[0] && sd_out[7:0] == $past(req_in.wdata[15:8], 3);
  endproperty
  steer_low_a: assert property (p_steer)
    else $error("upper byte not steered");
  idle_quiet_a: assert property (!busy_out |-> !bale_out)
    else $error("latch enable while idle");
endmodule
////////////////////////////////////////////////////////////////////////////////
bind isahc_cycle isahc_cycle_props i_isahc_cycle_props (.mclk_in, .rst_in, .req_valid_in,
  .req_in, .busy_out, .done_out, .cs16_n_in, .sd_out, .sd_oe_out, .sa_out, .la_out, .bale_out,
  .sbhe_n_out, .aen_out);

//--- isahc_periph.sv
// far-side peripheral model for the isa host cycle bench
`timescale 1ns/1ns
module isahc_periph
(
  // setup from the bench
  input wire logic wide16_in,
  // bus pins
  input wire logic [19:0] sa_in,
  input wire logic sbhe_n_in,
  input wire logic aen_in,
  output logic [15:0] sd_out,
  output logic cs16_n_out
);
  function automatic logic [7:0] pat(input logic [19:0] a);
    return a[7:0] ^ 8'h5A;
  endfunction
  assign cs16_n_out = !wide16_in;
  // lanes left undriven float up to the pull-ups
  assign sd_out = aen_in ? 16'hFFFF :
    wide16_in ? {sbhe_n_in ? 8'hFF : pat(sa_in | 20'h1), pat(sa_in & ~20'h1)} :
    {8'hFF, pat(sa_in)};
endmodule

//--- isahc_cycle_tb.sv
// self-checking bench for the isa host cycle sequencer
`timescale 1ns/1ns
module isahc_cycle_tb;
  import isahc_pkg::*;
  logic mclk_in = 1'b0;
  logic rst_in = 1'b1;
  logic req_valid_in = 1'b0;
  isahc_req_t req_in = '0;
  logic wide16 = 1'b0;
  logic busy_out, done_out, cs16_n_in, bale_out, sbhe_n_out, aen_out;
  logic [15:0] rdata_out, sd_in, sd_out, sdw;
  logic [1:0] sd_oe_out;
  logic [19:0] sa_out;
  logic [6:0] la_out;
  logic [28:0] cap;
  int nb, mismatches, cmp_count;
  initial forever #20 mclk_in = ~mclk_in;
  isahc_cycle i_isahc_cycle (.mclk_in, .rst_in, .req_valid_in, .req_in, .busy_out, .done_out,
    .rdata_out, .cs16_n_in, .sd_in, .sd_out, .sd_oe_out, .sa_out, .la_out, .bale_out,
    .sbhe_n_out, .aen_out);
  isahc_periph i_isahc_periph (.wide16_in(wide16), .sa_in(sa_out), .sbhe_n_in(sbhe_n_out),
    .aen_in(aen_out), .sd_out(sd_in), .cs16_n_out(cs16_n_in));
  //////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic ok, input string m);
    cmp_count++;
    if (ok !== 1'b1)
    begin
      mismatches++;
      $display("mismatch at %0t: %s", $time, m);
    end
  endtask
  task automatic give_verdict();
    $display("mismatches %0d, comparisons %0d", mismatches, cmp_count);
    if (mismatches == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // keeps the last address phase seen, so a split reports its second half
  task automatic xfer(input isahc_req_t r);
    nb = 0;
    @(negedge mclk_in);
    req_in = r;
    req_valid_in = 1'b1;
    @(negedge mclk_in);
    req_valid_in = 1'b0;
    for (int n = 0; n < 30 && done_out !== 1'b1; n++)
    begin
      if (bale_out === 1'b1)
      begin
        nb++;
        cap = {sa_out, la_out, sbhe_n_out, aen_out};
      end
      if (sd_oe_out[0] === 1'b1)
        sdw = sd_out;
      @(negedge mclk_in);
    end
    chk(done_out === 1'b1, "no done");
    chk(busy_out === 1'b0, "busy after done");
  endtask
  //////////////////////////////////////////////////////////////////////////////
  task automatic t_steer();
    wide16 = 1'b0;
    xfer('{24'h000123, 16'hC3A5, 1'b0, 1'b0, 1'b0, 1'b1});
    chk(sdw[7:0] === 8'hC3, "upper byte not on low lanes");
    chk(cap === {20'h00123, 7'h0, 1'b0, 1'b0}, "odd byte address phase");
    chk(nb == 2, "latch pulse length");
  endtask
  task automatic t_split();
    wide16 = 1'b0;
    xfer('{24'h000040, 16'h0, 1'b1, 1'b0, 1'b0, 1'b0});
    chk(nb == 4, "no split");
    chk(rdata_out === 16'h1B1A, "split read data");
    chk(cap === {20'h00041, 7'h0, 1'b1, 1'b0}, "second half address");
  endtask
  task automatic t_wide();
    wide16 = 1'b1;
    xfer('{24'h000040, 16'h0, 1'b1, 1'b0, 1'b0, 1'b0});
    chk(nb == 2, "wide cycle was split");
    chk(rdata_out === 16'h1B1A, "wide read data");
    chk(cap === {20'h00040, 7'h0, 1'b0, 1'b0}, "wide byte enable");
  endtask
  task automatic t_addr();
    wide16 = 1'b0;
    xfer('{24'hF2345E, 16'h0, 1'b0, 1'b0, 1'b0, 1'b0});
    chk(cap === {20'h2345E, 7'h79, 1'b1, 1'b0}, "memory address");
    chk(rdata_out[7:0] === 8'h04, "even byte read");
    xfer('{24'hF2345E, 16'h0, 1'b0, 1'b1, 1'b0, 1'b0});
    chk(cap === {20'h0345E, 7'h0, 1'b1, 1'b0}, "io address");
  endtask
  task automatic t_dma();
    xfer('{24'h000010, 16'h0, 1'b0, 1'b0, 1'b1, 1'b0});
    chk(cap === {20'h00010, 7'h0, 1'b1, 1'b1}, "dma aen");
    chk(rdata_out === 16'h00FF, "dma read lanes");
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (16) @(negedge mclk_in);
    rst_in = 1'b0;
    t_steer();
    t_split();
    t_wide();
    t_addr();
    t_dma();
    give_verdict();
  end
  // the whole run needs under a hundred cycles
  initial
  begin
    #80000;
    mismatches++;
    give_verdict();
  end
endmodule
